// *** hdl/dem_ctrl.sv ***
// controller end: issues load-mode commands for the extended registers
// assumes software on a plain strobe port and a bank-idle level from
// the rest of the controller, both on the same clock
// only load-mode and nop are ever driven, so no other command can leak
//
// The strobed register port and the register addresses were chosen for this implementation.

module dem_ctrl #(
  parameter bit ORG_X16 = 1'b0,
  parameter bit EXT_TEMP_GRADE = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  dem_link_if.ctrl link,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic banks_idle_in,
  output logic [15:0] reg_rdata_out,
  output logic busy_out
);
  dem_pkg::dem_state_t state_reg;
  logic [7:0] wait_cnt_reg;
  logic [12:0] ext1_val_reg;
  logic [12:0] ext2_cfg_reg;
  logic [12:0] ext1_sent_reg;
  logic [2:0] al_last_reg;
  logic [3:0] pend_reg;
  logic [2:0] done_reg;
  logic cke_reg;
  logic cke_prev_reg;
  logic cs_n_reg;
  logic cmd_n_reg;
  logic [1:0] ba_reg;
  logic [12:0] addr_reg;
  logic issue;
  logic [3:0] pick;
  logic [3:0] cmd_set;
  logic [12:0] ext1_eff;
  logic [12:0] ext2_eff;
  logic [12:0] exit_val;

  // link pins straight from flops
  assign link.cke = cke_reg;
  assign link.cs_n = cs_n_reg;
  assign link.ras_n = cmd_n_reg;
  assign link.cas_n = cmd_n_reg;
  assign link.we_n = cmd_n_reg;
  assign link.ba = ba_reg;
  assign link.addr = addr_reg;

  // software register writes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext1_val_reg <= dem_pkg::EXT_RST;
      ext2_cfg_reg <= dem_pkg::EXT_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == dem_pkg::REG_EXT1_VAL) begin
        ext1_val_reg <= reg_wdata_in[12:0];
      end
      if (reg_addr_in == dem_pkg::REG_EXT2_CFG) begin
        ext2_cfg_reg <= reg_wdata_in[12:0] & dem_pkg::EXT2_KEEP_MASK;
      end
    end
  end

  // load requests from the command register; init asks for all three
  always_comb begin
    cmd_set = 4'h0;
    if (reg_wr_in && reg_addr_in == dem_pkg::REG_CMD) begin
      cmd_set[dem_pkg::P_ONE] = reg_wdata_in[0] | reg_wdata_in[dem_pkg::CMD_INIT_BIT];
      cmd_set[dem_pkg::P_TWO] = reg_wdata_in[1] | reg_wdata_in[dem_pkg::CMD_INIT_BIT];
      cmd_set[dem_pkg::P_THREE] = reg_wdata_in[2] | reg_wdata_in[dem_pkg::CMD_INIT_BIT];
    end
  end

  // first register as sent: x16 drops the strobe copy, adjust keeps latency
  always_comb begin
    ext1_eff = ext1_val_reg;
    if (ORG_X16) begin
      ext1_eff[dem_pkg::EXT1_READ_STROBE_COPY_EN_BIT] = 1'b0;
    end
    if (ext1_val_reg[dem_pkg::EXT1_OCD_LSB +: 3] == dem_pkg::OCD_ADJUST) begin
      ext1_eff[dem_pkg::EXT1_AL_LSB +: 3] = al_last_reg;
    end
  end

  // second register as sent: commercial parts never get the hot rate
  always_comb begin
    ext2_eff = ext2_cfg_reg & dem_pkg::EXT2_KEEP_MASK;
    if (!EXT_TEMP_GRADE) begin
      ext2_eff[dem_pkg::EXT2_HTEMP_BIT] = 1'b0;
    end
  end

  // calibration exit repeats the last word with the program field cleared
  always_comb begin
    exit_val = ext1_sent_reg;
    exit_val[dem_pkg::EXT1_OCD_LSB +: 3] = dem_pkg::OCD_EXIT;
  end

  // one-hot pick of the lowest pending slot
  assign pick = pend_reg & (~pend_reg + 4'h1);

  // issue only when idle, banks precharged and cke high two edges
  assign issue = (state_reg == dem_pkg::DEM_IDLE) && (pend_reg != 4'h0) &&
                 banks_idle_in && cke_reg && cke_prev_reg;

  // pending slots; a new request in the issue cycle survives
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_reg <= 4'h0;
    end else begin
      pend_reg <= (pend_reg & ~(issue ? pick : 4'h0)) | cmd_set;
      if (issue && pick[dem_pkg::P_ONE] &&
          ext1_eff[dem_pkg::EXT1_OCD_LSB +: 3] == dem_pkg::OCD_DEFAULT) begin
        pend_reg[dem_pkg::P_EXIT] <= 1'b1;
      end
    end
  end

  // sequencer: one command cycle, then hold off for the set cycle time
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= dem_pkg::DEM_IDLE;
      wait_cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        dem_pkg::DEM_IDLE: begin
          if (issue) begin
            state_reg <= dem_pkg::DEM_WAIT;
            wait_cnt_reg <= dem_pkg::TMRD_LOAD;
          end
        end
        dem_pkg::DEM_WAIT: begin
          if (wait_cnt_reg == 8'h00) begin
            state_reg <= dem_pkg::DEM_IDLE;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // clock enable raised one edge after reset and kept high
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cke_reg <= 1'b0;
      cke_prev_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      cke_reg <= 1'b1;
      cke_prev_reg <= cke_reg;
      cs_n_reg <= 1'b0;
    end
  end

  // command pins: load-mode for one cycle, nop otherwise
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_n_reg <= 1'b1;
      ba_reg <= 2'h0;
      addr_reg <= dem_pkg::EXT_RST;
    end else if (issue) begin
      cmd_n_reg <= 1'b0;
      if (pick[dem_pkg::P_TWO]) begin
        ba_reg <= dem_pkg::BA_EXT_TWO;
        addr_reg <= ext2_eff;
      end else if (pick[dem_pkg::P_THREE]) begin
        ba_reg <= dem_pkg::BA_EXT_THREE;
        addr_reg <= dem_pkg::EXT_RST;
      end else if (pick[dem_pkg::P_ONE]) begin
        ba_reg <= dem_pkg::BA_EXT_ONE;
        addr_reg <= ext1_eff;
      end else begin
        ba_reg <= dem_pkg::BA_EXT_ONE;
        addr_reg <= exit_val;
      end
    end else begin
      cmd_n_reg <= 1'b1;
    end
  end

  // copy of what the device holds, for latency reuse and exit word
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext1_sent_reg <= dem_pkg::EXT_RST;
      al_last_reg <= 3'h0;
    end else if (issue && pick[dem_pkg::P_ONE]) begin
      ext1_sent_reg <= ext1_eff;
      al_last_reg <= ext1_eff[dem_pkg::EXT1_AL_LSB +: 3];
    end else if (issue && pick[dem_pkg::P_EXIT]) begin
      ext1_sent_reg <= exit_val;
    end
  end

  // which registers have been programmed at least once since reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_reg <= 3'h0;
    end else if (issue) begin
      done_reg <= done_reg | {pick[dem_pkg::P_ONE] | pick[dem_pkg::P_EXIT],
                              pick[dem_pkg::P_THREE], pick[dem_pkg::P_TWO]};
    end
  end

  // busy level for the rest of the controller
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (pend_reg != 4'h0) | cmd_set[0] | cmd_set[1] | cmd_set[2] |
                  (state_reg == dem_pkg::DEM_WAIT) | issue;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= dem_pkg::WORD_RST;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        dem_pkg::REG_EXT1_VAL: reg_rdata_out <= {3'h0, ext1_val_reg};
        dem_pkg::REG_EXT2_CFG: reg_rdata_out <= {3'h0, ext2_cfg_reg};
        dem_pkg::REG_CMD: reg_rdata_out <= {12'h000, pend_reg};
        dem_pkg::REG_STATUS: reg_rdata_out <= {10'h000, done_reg, &done_reg,
                                               pend_reg[dem_pkg::P_EXIT],
                                               state_reg == dem_pkg::DEM_WAIT};
        default: reg_rdata_out <= dem_pkg::WORD_RST;
      endcase
    end else begin
      reg_rdata_out <= dem_pkg::WORD_RST;
    end
  end
endmodule

// *** pkg/dem_pkg.sv ***
// constants shared by both ends of the extended mode register link
// assumes one 100 MHz clock for both ends and one bus word per register
package dem_pkg;
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 4;

  // bank address codes selecting each extended register
  localparam logic [1:0] BA_EXT_ONE = 2'h1;
  localparam logic [1:0] BA_EXT_TWO = 2'h2;
  localparam logic [1:0] BA_EXT_THREE = 2'h3;

  // first extended register field positions
  localparam int EXT1_AL_LSB = 3;
  localparam int EXT1_OCD_LSB = 7;
  localparam int EXT1_READ_STROBE_COPY_EN_BIT = 11;
  localparam int EXT1_QOFF_BIT = 12;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_ADJUST = 3'h4;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;

  // second extended register fields
  localparam int EXT2_HTEMP_BIT = 7;
  localparam int EXT2_PARTIAL_ARRAY_REFRESH_SEL_LSB = 0;
  localparam logic [12:0] EXT2_KEEP_MASK = 13'h0087;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_FULL = 3'h0;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_HALF = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_QUARTER = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_UNDEF = 3'h3;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_THREE_Q = 3'h4;

  // banks kept through self refresh for each range
  localparam logic [3:0] RETAIN_FULL = 4'hF;
  localparam logic [3:0] RETAIN_HALF = 4'h3;
  localparam logic [3:0] RETAIN_QUARTER = 4'h1;
  localparam logic [3:0] RETAIN_THREE_Q = 4'h7;
  localparam logic [3:0] RETAIN_NONE = 4'h0;

  // values after reset
  localparam logic [12:0] EXT_RST = 13'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // controller register offsets (byte addresses)
  localparam logic [3:0] REG_EXT1_VAL = 4'h0;
  localparam logic [3:0] REG_EXT2_CFG = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;

  // pending load slots, lower index goes first
  localparam int P_TWO = 0;
  localparam int P_THREE = 1;
  localparam int P_ONE = 2;
  localparam int P_EXIT = 3;
  localparam int CMD_INIT_BIT = 3;

  // mode register set cycle time
  localparam int SYS_CLK_MHZ = 100;
  localparam int TMRD_NS = 20;
  localparam int TMRD_CYCLES = (TMRD_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] TMRD_LOAD = 8'(TMRD_CYCLES - 1);

  typedef enum logic {DEM_IDLE = 1'b0, DEM_WAIT = 1'b1} dem_state_t;
endpackage

// *** pkg/dem_link_if.sv ***
// command and address wires between controller and memory device
// assumes both ends sample on the same rising edge of one clock
interface dem_link_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// *** hdl/dem_dev.sv ***
// memory device end: decodes load-mode commands into extended registers
// assumes link driven by logic on the same clock, so no synchroniser
module dem_dev (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  dem_link_if.dev link,
  output logic [12:0] ext_cfg_reg_one_out,
  output logic [12:0] ext_cfg_reg_two_out,
  output logic [12:0] ext_cfg_reg_three_out,
  output logic high_temp_refresh_en_out,
  output logic [2:0] partial_array_refresh_sel_out,
  output logic [3:0] bank_retain_out,
  output logic dq_drive_en_out,
  output logic read_strobe_copy_en_out
);
  logic cke_prev_reg;
  logic load_mode;

  // banks whose data survive self refresh for a range code
  function automatic logic [3:0] retain_map(input logic [2:0] sel);
    unique case (sel)
      dem_pkg::PARTIAL_ARRAY_REFRESH_SEL_FULL: retain_map = dem_pkg::RETAIN_FULL;
      dem_pkg::PARTIAL_ARRAY_REFRESH_SEL_HALF: retain_map = dem_pkg::RETAIN_HALF;
      dem_pkg::PARTIAL_ARRAY_REFRESH_SEL_QUARTER: retain_map = dem_pkg::RETAIN_QUARTER;
      dem_pkg::PARTIAL_ARRAY_REFRESH_SEL_THREE_Q: retain_map = dem_pkg::RETAIN_THREE_Q;
      default: retain_map = dem_pkg::RETAIN_NONE;
    endcase
  endfunction

  // clock enable of the previous edge
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= link.cke;
    end
  end

  // all four strobes low with cke high on both edges
  assign load_mode = cke_prev_reg & link.cke & ~link.cs_n & ~link.ras_n &
                     ~link.cas_n & ~link.we_n;

  // first extended register; accepted at any time, also mid operation
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cfg_reg_one_out <= dem_pkg::EXT_RST;
      dq_drive_en_out <= 1'b1;
      read_strobe_copy_en_out <= 1'b0;
    end else if (load_mode && link.ba == dem_pkg::BA_EXT_ONE) begin
      ext_cfg_reg_one_out <= link.addr;
      dq_drive_en_out <= ~link.addr[dem_pkg::EXT1_QOFF_BIT];
      read_strobe_copy_en_out <= link.addr[dem_pkg::EXT1_READ_STROBE_COPY_EN_BIT];
    end
  end

  // second extended register, contents held until reloaded
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cfg_reg_two_out <= dem_pkg::EXT_RST;
      high_temp_refresh_en_out <= 1'b0;
      partial_array_refresh_sel_out <= dem_pkg::PARTIAL_ARRAY_REFRESH_SEL_FULL;
      bank_retain_out <= dem_pkg::RETAIN_FULL;
    end else if (load_mode && link.ba == dem_pkg::BA_EXT_TWO) begin
      ext_cfg_reg_two_out <= link.addr;
      high_temp_refresh_en_out <= link.addr[dem_pkg::EXT2_HTEMP_BIT];
      partial_array_refresh_sel_out <= link.addr[dem_pkg::EXT2_PARTIAL_ARRAY_REFRESH_SEL_LSB +: 3];
      // undefined code keeps nothing: worst case for self refresh
      bank_retain_out <= retain_map(link.addr[dem_pkg::EXT2_PARTIAL_ARRAY_REFRESH_SEL_LSB +: 3]);
    end
  end

  // third extended register: stored only, no function
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_cfg_reg_three_out <= dem_pkg::EXT_RST;
    end else if (load_mode && link.ba == dem_pkg::BA_EXT_THREE) begin
      ext_cfg_reg_three_out <= link.addr;
    end
  end
endmodule

// *** tb/dem_link_properties.sv ***
// checker for the load-mode wires between controller and device
// assumes one clock for both ends and an active low async reset
module dem_link_properties #(
  parameter bit ORG_X16 = 1'b0,
  parameter bit EXT_TEMP_GRADE = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] ba_in,
  input wire logic [12:0] addr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic load;
  // load-mode decode, all four strobes low together
  assign load = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;

  property p_cke_before;
    load |-> cke_in && $past(cke_in);
  endproperty
  a_cke_before: assert property (p_cke_before)
    else $error("load-mode without cke high on two edges");
  property p_spacing;
    load |=> !load ##1 !load;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("load-mode repeated inside the cycle time");
  property p_only_lmr;
    ras_n_in == cas_n_in && cas_n_in == we_n_in;
  endproperty
  a_only_lmr: assert property (p_only_lmr)
    else $error("command other than load-mode or nop");
  property p_sel_valid;
    load |-> ba_in != 2'h0;
  endproperty
  a_sel_valid: assert property (p_sel_valid)
    else $error("load-mode without an extended register select");
  property p_two_rsv;
    load && ba_in == dem_pkg::BA_EXT_TWO |->
      (addr_in & ~dem_pkg::EXT2_KEEP_MASK) == 13'h0000;
  endproperty
  a_two_rsv: assert property (p_two_rsv)
    else $error("reserved bits set in second register word");
  property p_two_temp;
    load && ba_in == dem_pkg::BA_EXT_TWO && !EXT_TEMP_GRADE |->
      !addr_in[dem_pkg::EXT2_HTEMP_BIT];
  endproperty
  a_two_temp: assert property (p_two_temp)
    else $error("high temperature rate on a standard grade");
  property p_three_zero;
    load && ba_in == dem_pkg::BA_EXT_THREE |-> addr_in == 13'h0000;
  endproperty
  a_three_zero: assert property (p_three_zero)
    else $error("third register word not zero");
  property p_x16;
    load && ba_in == dem_pkg::BA_EXT_ONE && ORG_X16 |-> !addr_in[dem_pkg::EXT1_READ_STROBE_COPY_EN_BIT];
  endproperty
  a_x16: assert property (p_x16)
    else $error("strobe copy enabled on the wide part");
  // exit must follow the default setting while banks stay idle
  property p_calib_exit;
    load && ba_in == dem_pkg::BA_EXT_ONE &&
      addr_in[dem_pkg::EXT1_OCD_LSB +: 3] == dem_pkg::OCD_DEFAULT |->
      ##[3:40] (load && ba_in == dem_pkg::BA_EXT_ONE &&
                addr_in[dem_pkg::EXT1_OCD_LSB +: 3] == dem_pkg::OCD_EXIT);
  endproperty
  a_calib_exit: assert property (p_calib_exit)
    else $error("calibration default not followed by exit");
  c_one: cover property (load && ba_in == dem_pkg::BA_EXT_ONE);
  c_two: cover property (load && ba_in == dem_pkg::BA_EXT_TWO);
  c_three: cover property (load && ba_in == dem_pkg::BA_EXT_THREE);
  c_calib: cover property (load && addr_in[dem_pkg::EXT1_OCD_LSB +: 3] == dem_pkg::OCD_DEFAULT);
endmodule

// *** tb/dram_extended_mode_regs_tb_top.sv ***
// bench joining controller and device over the link interface
// assumes the register port of the controller and one 100 MHz clock
module dram_extended_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic banks_idle = 1'b1;
  logic [15:0] reg_rdata;
  logic busy;
  logic [12:0] ext_one;
  logic [12:0] ext_two;
  logic [12:0] ext_three;
  logic htemp_en;
  logic rsc_en;
  logic dq_en;
  logic [2:0] partial_array_refresh_sel;
  logic [3:0] retain;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // range codes and the banks each one keeps
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [3:0] keeps [5] = '{4'hF, 4'h3, 4'h1, 4'h7, 4'h0};

  always #5 sys_clk_in = ~sys_clk_in;

  dem_link_if dem_link_if_i ();
  // wide part, standard grade: both forcing paths get exercised
  dem_ctrl #(.ORG_X16(1'b1), .EXT_TEMP_GRADE(1'b0)) dem_ctrl_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(dem_link_if_i),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .banks_idle_in(banks_idle), .reg_rdata_out(reg_rdata),
    .busy_out(busy));
  dem_dev dem_dev_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(dem_link_if_i),
    .ext_cfg_reg_one_out(ext_one), .ext_cfg_reg_two_out(ext_two),
    .ext_cfg_reg_three_out(ext_three), .high_temp_refresh_en_out(htemp_en),
    .partial_array_refresh_sel_out(partial_array_refresh_sel), .bank_retain_out(retain),
    .dq_drive_en_out(dq_en), .read_strobe_copy_en_out(rsc_en));
  dem_link_properties #(.ORG_X16(1'b1), .EXT_TEMP_GRADE(1'b0)) dem_link_properties_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cke_in(dem_link_if_i.cke),
    .cs_n_in(dem_link_if_i.cs_n), .ras_n_in(dem_link_if_i.ras_n),
    .cas_n_in(dem_link_if_i.cas_n), .we_n_in(dem_link_if_i.we_n),
    .ba_in(dem_link_if_i.ba), .addr_in(dem_link_if_i.addr));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input string what, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  // busy is registered and lags, so give it a few edges first
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk_in);
    while (busy !== 1'b0 && n < 200) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("wrong value busy expected 0 seen %b", busy);
    end
    @(negedge sys_clk_in);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 135 cycles the tests need
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wr(dem_pkg::REG_EXT1_VAL, 16'h0818);
    wr(dem_pkg::REG_EXT2_CFG, 16'hFFFF);
    wr(dem_pkg::REG_CMD, 16'h0008);
    wait_idle();
    chk("ext one", 16'h0018, {3'h0, ext_one});
    chk("ext two", 16'h0007, {3'h0, ext_two});
    chk("ext three", 16'h0000, {3'h0, ext_three});
    chk("high temp", 16'h0000, {15'h0, htemp_en});
    chk("retain", 16'h0000, {12'h0, retain});
    chk("strobe copy", 16'h0000, {15'h0, rsc_en});
    rd(dem_pkg::REG_EXT2_CFG, "cfg two", 16'h0087);
    rd(4'h2, "unmapped", 16'h0000);
    rd(dem_pkg::REG_STATUS, "status", 16'h003C);
    $display("test init done");
    // every range code, each a rewrite with banks idle
    foreach (codes[i]) begin
      wr(dem_pkg::REG_EXT2_CFG, {13'h0, codes[i]});
      wr(dem_pkg::REG_CMD, 16'h0002);
      wait_idle();
      chk("range", {13'h0, codes[i]}, {13'h0, partial_array_refresh_sel});
      chk("retain", {12'h0, keeps[i]}, {12'h0, retain});
    end
    $display("test ranges done");
    @(posedge sys_clk_in);
    banks_idle <= 1'b0;
    wr(dem_pkg::REG_EXT2_CFG, 16'h0081);
    wr(dem_pkg::REG_CMD, 16'h0002);
    repeat (10) @(posedge sys_clk_in);
    #1;
    chk("ext two held", 16'h0003, {3'h0, ext_two});
    chk("busy", 16'h0001, {15'h0, busy});
    rd(dem_pkg::REG_CMD, "pending", 16'h0001);
    @(posedge sys_clk_in);
    banks_idle <= 1'b1;
    wait_idle();
    chk("ext two", 16'h0001, {3'h0, ext_two});
    $display("test banks busy done");
    wr(dem_pkg::REG_EXT1_VAL, 16'h1398);
    wr(dem_pkg::REG_CMD, 16'h0001);
    wait_idle();
    chk("calib exit", 16'h1018, {3'h0, ext_one});
    chk("dq drive off", 16'h0000, {15'h0, dq_en});
    wr(dem_pkg::REG_EXT1_VAL, 16'h0200);
    wr(dem_pkg::REG_CMD, 16'h0001);
    wait_idle();
    chk("adjust", 16'h0218, {3'h0, ext_one});
    chk("dq drive on", 16'h0001, {15'h0, dq_en});
    chk("two kept", 16'h0001, {3'h0, ext_two});
    chk("three kept", 16'h0000, {3'h0, ext_three});
    $display("test calibration done");
    stop_test();
  end
endmodule
